// ### src/dbgsl_flag.sv
// Sticky flag cell: hardware set wins over any clear in the same cycle
`timescale 1ns/1ps
module dbgsl_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Flag events
  input wire logic set,
  input wire logic clr,
  // Flag state
  output logic q
);
  typedef struct packed {
    logic flag;
  } dbgsl_flag_st_t;

  dbgsl_flag_st_t st_q;
  dbgsl_flag_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (set) begin
      st_d.flag = 1'b1;
    end else if (clr) begin
      st_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{flag: RESET_VAL};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.flag;
endmodule

// ### src/dbgsl_pkg.sv
// Constants for the lower debug status register and acknowledge shaping
// Operation
// [R1] Status reached only by debug link commands
// [R2] Link reads; writes of one clear flags
// [R3] Overrun ignores writes; cleared only by sync
// [R4] Flag-setting acknowledged command gets long acknowledge
// [R5] Later good commands normal, failing commands long
// [R6] First acknowledge after wait/stop set is long
// [R7] No immediate long acknowledge on pin overrun
// [R8] After a full byte, overrun forces long
// [R9] Unimplemented opcode gives no long acknowledge
// [R10] Other illegal-command causes give long acknowledge
// [R11] Wait flag sets on wait; clears after exit
// [R12] Stop flag sets on stop request; clears outside
// [R13] Stop flag sets only while controller enabled
// [R14] RAM write fault sets on double fault
// [R15] Overrun sets on command before completion
// [R16] Overrun sets on pin low during pending acknowledge
// [R17] Overrun suppresses internal accesses until sync
package dbgsl_pkg;
  localparam int STATUS_W = 8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BIT_WAIT = 7;
  localparam int BIT_STOP = 6;
  localparam int BIT_RAM_WRITE_FAULT_FLAG = 5;
  localparam int BIT_OVRN = 4;
  localparam int BIT_NORESP = 3;
  localparam int BIT_RDINV = 2;
  localparam int BIT_ILLACC = 1;
  localparam int BIT_ILLEGAL_COMMAND_FLAG = 0;
  // Bits that a written one may clear; the overrun bit is excluded
  localparam logic [7:0] WRITE_CLEAR_MASK = 8'hef;
endpackage

// ### src/dbgsl_status.sv
// Lower debug status register with flag rules and long/normal acknowledge choice
`timescale 1ns/1ps
module dbgsl_status
  import dbgsl_pkg::*;
#(
  parameter int WIDTH = dbgsl_pkg::STATUS_W
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Status commands from the link decoder
  input wire logic WR_STATUS,
  input wire logic [WIDTH-1:0] WR_DATA,
  // Device mode inputs
  input wire logic WAIT_MODE,
  input wire logic STOP_REQ,
  input wire logic IN_STOP,
  input wire logic CTRL_ENABLE,
  // Flag setting conditions
  input wire logic RAM_DBL_FAULT,
  input wire logic NORESP_SET,
  input wire logic RDINV_SET,
  input wire logic ILLACC_SET,
  input wire logic ILLEGAL_COMMAND_FLAG_SET,
  input wire logic ILLEGAL_COMMAND_FLAG_UNIMPL,
  // Link activity
  input wire logic CMD_START,
  input wire logic CMD_BUSY,
  input wire logic ACK_EN,
  input wire logic ACK_PENDING,
  input wire logic PIN_LOW,
  input wire logic BYTE_RCVD,
  input wire logic SYNC_PULSE,
  input wire logic ACK_REQ,
  // Results
  output logic [WIDTH-1:0] STATUS,
  output logic ACK_GO,
  output logic ACK_LONG,
  output logic ACCESS_SUPPRESS
);
  initial begin
    if (WIDTH != STATUS_W) begin
      $error("dbgsl_status: WIDTH must be 8");
    end
  end

  typedef struct packed {
    logic ack_go;
    logic ack_long;
    logic cmd_err;
    logic ws_first;
    logic ovr_hold;
  } dbgsl_st_t;

  dbgsl_st_t st_q;
  dbgsl_st_t st_d;

  logic [7:0] flag_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] wr_clr;
  logic ovr_cmd;
  logic ovr_pin;
  logic err_now;
  logic ack_issue;
  logic long_now;

  // Write-one-to-clear, only by the status write command
  assign wr_clr = (WR_STATUS ? WR_DATA : 8'h00) & WRITE_CLEAR_MASK; // [R1] [R2]

  assign ovr_cmd = CMD_START & CMD_BUSY; // [R15]
  assign ovr_pin = ACK_EN & ACK_PENDING & PIN_LOW; // [R16]

  // Flag setting conditions; illegal-command only counts when not an unknown opcode
  assign err_now = NORESP_SET | RDINV_SET | ILLACC_SET | (ILLEGAL_COMMAND_FLAG_SET & ~ILLEGAL_COMMAND_FLAG_UNIMPL); // [R4] [R5] [R10]

  always_comb begin
    flag_set = 8'h00;
    flag_clr = 8'h00;
    flag_set[BIT_WAIT] = WAIT_MODE; // [R11]
    flag_clr[BIT_WAIT] = wr_clr[BIT_WAIT] & ~WAIT_MODE; // [R11]
    flag_set[BIT_STOP] = STOP_REQ & CTRL_ENABLE; // [R12] [R13]
    flag_clr[BIT_STOP] = wr_clr[BIT_STOP] & ~IN_STOP; // [R12]
    flag_set[BIT_RAM_WRITE_FAULT_FLAG] = RAM_DBL_FAULT; // [R14]
    flag_clr[BIT_RAM_WRITE_FAULT_FLAG] = wr_clr[BIT_RAM_WRITE_FAULT_FLAG]; // [R14]
    flag_set[BIT_OVRN] = ovr_cmd | ovr_pin; // [R15] [R16]
    flag_clr[BIT_OVRN] = SYNC_PULSE; // [R3]
    flag_set[BIT_NORESP] = NORESP_SET;
    flag_clr[BIT_NORESP] = wr_clr[BIT_NORESP]; // [R2]
    flag_set[BIT_RDINV] = RDINV_SET;
    flag_clr[BIT_RDINV] = wr_clr[BIT_RDINV]; // [R2]
    flag_set[BIT_ILLACC] = ILLACC_SET;
    flag_clr[BIT_ILLACC] = wr_clr[BIT_ILLACC]; // [R2]
    flag_set[BIT_ILLEGAL_COMMAND_FLAG] = ILLEGAL_COMMAND_FLAG_SET;
    flag_clr[BIT_ILLEGAL_COMMAND_FLAG] = wr_clr[BIT_ILLEGAL_COMMAND_FLAG]; // [R2]
  end

  for (genvar i = 0; i < 8; i++) begin : g_flag
    dbgsl_flag #(
      .RESET_VAL(STATUS_RESET[i])
    ) u_flag (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .set(flag_set[i]),
      .clr(flag_clr[i]),
      .q(flag_q[i])
    );
  end

  // Unknown opcodes get no acknowledge at all, the host may still be sending
  assign ack_issue = ACK_REQ & ACK_EN & ~ILLEGAL_COMMAND_FLAG_UNIMPL; // [R9]

  // Pin-low overrun forces long only once a full byte followed the offending edge; command overrun forces it at once
  assign long_now = st_q.cmd_err | err_now | st_q.ws_first
    | (flag_q[BIT_OVRN] & ~st_q.ovr_hold & ~ovr_pin); // [R4] [R5] [R6] [R7] [R8] [R10]

  always_comb begin
    st_d = st_q;
    st_d.ack_go = ack_issue;
    if (ack_issue) begin
      st_d.ack_long = long_now;
    end
    // Errors seen during the command shape its acknowledge, then are forgotten
    if (ack_issue) begin
      st_d.cmd_err = 1'b0;
    end else if (err_now) begin
      st_d.cmd_err = 1'b1; // [R5]
    end
    // A fresh wait or stop entry arms one long acknowledge; arming wins over use
    if ((WAIT_MODE & ~flag_q[BIT_WAIT]) | (flag_set[BIT_STOP] & ~flag_q[BIT_STOP])) begin
      st_d.ws_first = 1'b1; // [R6]
    end else if (ack_issue) begin
      st_d.ws_first = 1'b0; // [R6]
    end
    if (ovr_pin) begin
      st_d.ovr_hold = 1'b1; // [R7]
    end else if (BYTE_RCVD | SYNC_PULSE) begin
      st_d.ovr_hold = 1'b0; // [R8]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= '0;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  assign STATUS = flag_q;
  assign ACK_GO = st_q.ack_go;
  assign ACK_LONG = st_q.ack_long;
  // Gate for all link-requested internal accesses
  assign ACCESS_SUPPRESS = flag_q[BIT_OVRN]; // [R17]

  a_ovr_write_ignored: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    (CE && STATUS[BIT_OVRN] && WR_STATUS && WR_DATA[BIT_OVRN] && !SYNC_PULSE) |=> STATUS[BIT_OVRN])
    else $error("overrun flag cleared by a write");

  a_ovr_sync_clear: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    (CE && SYNC_PULSE && !ovr_cmd && !ovr_pin) |=> !STATUS[BIT_OVRN])
    else $error("sync did not clear overrun");

  a_ovr_set_suppress: assert property (@(posedge CLK) disable iff (!RST_N) // [R15] [R16] [R17]
    (CE && (CMD_START && CMD_BUSY || ACK_EN && ACK_PENDING && PIN_LOW)) |=> ACCESS_SUPPRESS)
    else $error("overrun condition did not suppress accesses");

  a_stop_needs_enable: assert property (@(posedge CLK) disable iff (!RST_N) // [R13]
    (CE && !CTRL_ENABLE && !STATUS[BIT_STOP]) |=> !STATUS[BIT_STOP])
    else $error("stop flag set while controller disabled");

  a_stop_clear_blocked: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
    (STATUS[BIT_STOP] && IN_STOP && WR_STATUS && WR_DATA[BIT_STOP]) |=> STATUS[BIT_STOP])
    else $error("stop flag cleared during stop mode");

  a_wait_clear_rules: assert property (@(posedge CLK) disable iff (!RST_N) // [R11]
    (CE && WR_STATUS && WR_DATA[BIT_WAIT]) |=> (STATUS[BIT_WAIT] == $past(WAIT_MODE)))
    else $error("wait flag write-clear handled wrongly");

  a_ram_write_fault_flag_set_clear: assert property (@(posedge CLK) disable iff (!RST_N) // [R14]
    (CE && RAM_DBL_FAULT) |=> STATUS[BIT_RAM_WRITE_FAULT_FLAG] ##0 (!(CE && WR_STATUS && WR_DATA[BIT_RAM_WRITE_FAULT_FLAG]
      && !RAM_DBL_FAULT) or ##1 !STATUS[BIT_RAM_WRITE_FAULT_FLAG]))
    else $error("ram write fault flag misbehaves");

  a_err_ack_long: assert property (@(posedge CLK) disable iff (!RST_N) // [R4] [R10]
    (CE && ACK_REQ && ACK_EN && !ILLEGAL_COMMAND_FLAG_UNIMPL && (NORESP_SET || RDINV_SET || ILLACC_SET || ILLEGAL_COMMAND_FLAG_SET))
    |=> (ACK_GO && ACK_LONG))
    else $error("flagged command did not give a long acknowledge");

  a_unimpl_no_ack: assert property (@(posedge CLK) disable iff (!RST_N) // [R9]
    (CE && ILLEGAL_COMMAND_FLAG_UNIMPL) |=> !ACK_GO)
    else $error("acknowledge sent for unimplemented opcode");

  a_good_ack_normal: assert property (@(posedge CLK) disable iff (!RST_N) // [R5] [R6]
    (CE && ack_issue && !err_now && !st_q.cmd_err && !st_q.ws_first && !STATUS[BIT_OVRN]) |=> !ACK_LONG)
    else $error("correct command gave a long acknowledge");

  a_first_ws_long: assert property (@(posedge CLK) disable iff (!RST_N) // [R6]
    (CE && !STATUS[BIT_WAIT] && WAIT_MODE) ##1 (CE && ack_issue) |=> ACK_LONG)
    else $error("first acknowledge after wait entry was not long");

  a_ovr_hold_normal: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    (CE && ack_issue && st_q.ovr_hold && !err_now && !st_q.cmd_err && !st_q.ws_first) |=> !ACK_LONG)
    else $error("long acknowledge during host transmission after overrun");

  a_ovr_byte_long: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    (CE && ack_issue && STATUS[BIT_OVRN] && !st_q.ovr_hold && !ovr_pin) |=> ACK_LONG)
    else $error("overrun did not force a long acknowledge");
endmodule

// ### verification/dbgsl_host.sv
// Debug host model: drives link events toward the status block
`timescale 1ns/1ps
module dbgsl_host (
  // Clock
  input wire logic clk,
  // Link events
  output logic wr_status,
  output logic [7:0] wr_data,
  output logic cmd_start,
  output logic pin_low,
  output logic byte_rcvd,
  output logic sync_pulse
);
  initial begin
    {sync_pulse, byte_rcvd, pin_low, cmd_start, wr_status} = 5'h00;
    wr_data = 8'h00;
  end
  // Ops: 0 write status, 1 command start, 2 pin low, 3 byte received, 4 sync
  task automatic send(input logic [2:0] op, input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    {sync_pulse, byte_rcvd, pin_low, cmd_start, wr_status} = 5'h01 << op;
    @(negedge clk);
    {sync_pulse, byte_rcvd, pin_low, cmd_start, wr_status} = 5'h00;
    // Data no longer valid: show the inverse so a stale copy cannot pass
    wr_data = ~d;
  endtask
endmodule

// ### verification/dbgsl_status_bench.sv
// Self-checking bench for the lower debug status register and acknowledge choice
`timescale 1ns/1ps
module dbgsl_status_bench;
  import dbgsl_pkg::*;
  logic clk, rst_n, ce, wait_mode, stop_req, in_stop, ctrl_enable, ram_dbl_fault, ack_req;
  logic noresp_set, rdinv_set, illacc_set, illegal_command_flag_set, illegal_command_flag_unimpl, cmd_busy, ack_en, ack_pending;
  logic wr_status, cmd_start, pin_low, byte_rcvd, sync_pulse, ack_go, ack_long, access_suppress;
  logic [7:0] wr_data, status;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  dbgsl_host u_dbgsl_host (.clk(clk), .wr_status(wr_status), .wr_data(wr_data), .cmd_start(cmd_start),
    .pin_low(pin_low), .byte_rcvd(byte_rcvd), .sync_pulse(sync_pulse));

  dbgsl_status u_dbgsl_status (.CLK(clk), .RST_N(rst_n), .CE(ce), .WR_STATUS(wr_status), .WR_DATA(wr_data),
    .WAIT_MODE(wait_mode), .STOP_REQ(stop_req), .IN_STOP(in_stop), .CTRL_ENABLE(ctrl_enable),
    .RAM_DBL_FAULT(ram_dbl_fault), .NORESP_SET(noresp_set), .RDINV_SET(rdinv_set), .ILLACC_SET(illacc_set),
    .ILLEGAL_COMMAND_FLAG_SET(illegal_command_flag_set), .ILLEGAL_COMMAND_FLAG_UNIMPL(illegal_command_flag_unimpl), .CMD_START(cmd_start), .CMD_BUSY(cmd_busy),
    .ACK_EN(ack_en), .ACK_PENDING(ack_pending), .PIN_LOW(pin_low), .BYTE_RCVD(byte_rcvd),
    .SYNC_PULSE(sync_pulse), .ACK_REQ(ack_req), .STATUS(status), .ACK_GO(ack_go), .ACK_LONG(ack_long),
    .ACCESS_SUPPRESS(access_suppress));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_st(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_ack(input logic e_go, input logic e_long);
    n_tests++;
    if ({ack_go, ack_long} !== {e_go, e_long}) begin
      fails++;
      $display("Error ack expected %b%b seen %b%b", e_go, e_long, ack_go, ack_long);
    end
  endtask

  // One cycle of event pulses; outputs of the taking edge are settled on return
  task automatic step(input logic [7:0] p);
    @(negedge clk);
    {stop_req, ram_dbl_fault, ack_req, illegal_command_flag_unimpl, illegal_command_flag_set, illacc_set, rdinv_set, noresp_set} = p;
    @(negedge clk);
    {stop_req, ram_dbl_fault, ack_req, illegal_command_flag_unimpl, illegal_command_flag_set, illacc_set, rdinv_set, noresp_set} = 8'h00;
  endtask

  initial begin
    {rst_n, wait_mode, stop_req, in_stop, ram_dbl_fault, ack_req, cmd_busy, ack_pending} = 8'h00;
    {noresp_set, rdinv_set, illacc_set, illegal_command_flag_set, illegal_command_flag_unimpl} = 5'h00;
    {ce, ctrl_enable, ack_en} = 3'h7;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk_st("status", 8'h00, status);
    step(8'hcf);
    chk_st("status", 8'h6f, status);
    wait_mode = 1'b1;
    step(8'h00);
    wait_mode = 1'b0;
    chk_st("status", 8'hef, status);
    cmd_busy = 1'b1;
    u_dbgsl_host.send(3'h1, 8'h00);
    cmd_busy = 1'b0;
    chk_st("status", 8'hff, status);
    chk_st("suppress", 8'h01, {7'h00, access_suppress});
    {wait_mode, in_stop} = 2'h3;
    u_dbgsl_host.send(3'h0, 8'hff);
    chk_st("status", 8'hd0, status);
    {wait_mode, in_stop} = 2'h0;
    u_dbgsl_host.send(3'h0, 8'hff);
    chk_st("status", 8'h10, status);
    u_dbgsl_host.send(3'h4, 8'h00);
    chk_st("status", 8'h00, status);
    chk_st("suppress", 8'h00, {7'h00, access_suppress});
    ctrl_enable = 1'b0;
    step(8'h80);
    ctrl_enable = 1'b1;
    chk_st("status", 8'h00, status);
    step(8'h20);
    chk_ack(1'b1, 1'b1);
    step(8'h20);
    chk_ack(1'b1, 1'b0);
    // Each of the three flag conditions of bits 3..1 in turn
    for (int i = 0; i < 3; i++) begin
      step(8'h20 | (8'h01 << i));
      chk_ack(1'b1, 1'b1);
      step(8'h20);
      chk_ack(1'b1, 1'b0);
    end
    step(8'h21);
    chk_ack(1'b1, 1'b1);
    step(8'h28);
    chk_ack(1'b1, 1'b1);
    step(8'h20);
    step(8'h38);
    chk_ack(1'b0, 1'b0);
    ack_en = 1'b0;
    step(8'h20);
    ack_en = 1'b1;
    chk_ack(1'b0, 1'b0);
    u_dbgsl_host.send(3'h0, 8'hff);
    ack_pending = 1'b1;
    u_dbgsl_host.send(3'h2, 8'h00);
    ack_pending = 1'b0;
    chk_st("status", 8'h10, status);
    step(8'h20);
    chk_ack(1'b1, 1'b0);
    u_dbgsl_host.send(3'h3, 8'h00);
    step(8'h20);
    chk_ack(1'b1, 1'b1);
    step(8'h20);
    chk_ack(1'b1, 1'b1);
    u_dbgsl_host.send(3'h4, 8'h00);
    step(8'h20);
    chk_ack(1'b1, 1'b0);
    close_out();
  end
endmodule
